// >>> shared/bus_pin_mux_pkg.sv
// constants, register map and carrier types for the bus control pin multiplexer
package bus_pin_mux_pkg;

   // register byte offsets on the AXI4-Lite slave
   localparam logic [7:0] ADDR_FUNC_SEL = 8'h00;
   localparam logic [7:0] ADDR_PORT_DATA = 8'h04;
   localparam logic [7:0] ADDR_PORT_DIR = 8'h08;
   localparam logic [7:0] ADDR_PIN_STATE = 8'h0c;
   localparam logic [7:0] ADDR_STATUS = 8'h10;

   // values after reset: every pin starts as a port input
   localparam logic [9:0] FUNC_SEL_RST = 10'h000;
   localparam logic [7:0] PORT_DATA_RST = 8'h00;
   localparam logic [7:0] PORT_DIR_RST = 8'h00;

   // status field positions
   localparam int STAT_SYS_RUN = 0;
   localparam int STAT_MEM_RUN = 1;
   localparam int STAT_STANDBY = 2;
   localparam int STAT_SLEEP = 3;
   localparam int STAT_STOP = 4;

   // AXI response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // clock: 100 MHz core, bus clock half period in core cycles
   localparam int CLK_PERIOD_NS = 10;
   localparam int BUS_HALF_NS = 20;
   localparam int BUS_HALF_CYC_DEF = (BUS_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // function settings, one enable per shared pin function
   typedef struct packed {
      logic sram_mode; // write strobe pins carry byte masks
      logic we_en; // bit 8: 16-bit SRAM write strobe
      logic cas_en; // bit 7: column address strobe
      logic adv_en; // bit 6: burst address advance
      logic load_en; // bit 5: burst address load
      logic addr_strobe_en; // bit 4: address strobe
      logic reinput_en; // bit 3: SDRAM clock re-input
      logic mclk_en; // bit 2: memory clock
      logic cke_en; // bit 1: SDRAM clock enable
      logic sys_clk_en; // bit 0: system clock
   } func_sel_type;

   // strobes arriving from the external bus controller
   typedef struct packed {
      logic wr1;
      logic wr0;
      logic upper_byte_mask;
      logic lower_byte_mask;
      logic we;
      logic cas;
      logic burst_address_advance_out;
      logic burst_address_load_out;
      logic address_strobe_out;
      logic cke;
   } bus_strobe_type;

endpackage : bus_pin_mux_pkg

// >>> logic/bus_control_pin_mux.sv
// shared clock and bus strobe pin multiplexer with AXI4-Lite control registers
//
// Chosen here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module bus_control_pin_mux
   import bus_pin_mux_pkg::*;
#(
   parameter int unsigned BUS_HALF = BUS_HALF_CYC_DEF
) (
   input wire logic CLK_I,
   input wire logic ARST_N_I,
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic SLEEP_I,
   input wire logic STOP_I,
   input wire logic HARDWARE_STANDBY_IN_I,
   input wire bus_strobe_type STROBE_I,
   input wire logic [7:0] PIN_I,
   output logic [7:0] PIN_O,
   output logic [7:0] PIN_OE_O,
   output logic CLK_REIN_O,
   output logic WR0_O,
   output logic WR1_O
);

   func_sel_type func_r;
   logic [7:0] data_r;
   logic [7:0] dir_r;
   logic aw_hold_r;
   logic w_hold_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [1:0] rresp_r;
   logic [31:0] rdata_r;
   logic [7:0] pin_meta_r;
   logic [7:0] pin_sync_r;
   logic stby_meta_r;
   logic stby_sync_r;
   logic [7:0] div_cnt_r;
   logic bus_ck_r;
   logic sys_ck_r;
   logic mem_ck_r;
   logic [7:0] pin_out_r;
   logic [7:0] pin_oe_r;
   logic wr0_r;
   logic wr1_r;
   logic [7:0] pin_out_nxt;
   logic [7:0] pin_oe_nxt;
   logic [7:0] port_mode;
   logic sys_halt;
   logic mem_halt;
   logic do_write;
   logic [31:0] read_mux;
   logic read_hit;

   // merge written bytes into an old word under the byte strobes
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old_w;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_w[i*8 +: 8];
         end
      end
      return res;
   endfunction : merge_bytes

   // two-flop synchronisers for the pins and the standby input
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         pin_meta_r <= 8'h00;
         pin_sync_r <= 8'h00;
         stby_meta_r <= 1'b0;
         stby_sync_r <= 1'b0;
      end else begin
         pin_meta_r <= PIN_I;
         pin_sync_r <= pin_meta_r;
         stby_meta_r <= HARDWARE_STANDBY_IN_I;
         stby_sync_r <= stby_meta_r;
      end
   end

   // write channel: address and data taken in either order
   assign S_AXI_AWREADY = !aw_hold_r && !bvalid_r;
   assign S_AXI_WREADY = !w_hold_r && !bvalid_r;
   assign do_write = aw_hold_r && w_hold_r && !bvalid_r;

   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_hold_r <= 1'b1;
            awaddr_r <= S_AXI_AWADDR;
         end else if (do_write) begin
            aw_hold_r <= 1'b0;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_hold_r <= 1'b1;
            wdata_r <= S_AXI_WDATA;
            wstrb_r <= S_AXI_WSTRB;
         end else if (do_write) begin
            w_hold_r <= 1'b0;
         end
      end
   end

   // register updates and write response
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         func_r <= FUNC_SEL_RST;
         data_r <= PORT_DATA_RST;
         dir_r <= PORT_DIR_RST;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else begin
         if (do_write) begin
            bvalid_r <= 1'b1;
            bresp_r <= RESP_OKAY;
            unique case ({awaddr_r[7:2], 2'b00})
               ADDR_FUNC_SEL: begin
                  func_r <= func_sel_type'(10'(merge_bytes({22'h0, func_r}, wdata_r, wstrb_r)));
               end
               ADDR_PORT_DATA: begin
                  data_r <= 8'(merge_bytes({24'h0, data_r}, wdata_r, wstrb_r));
               end
               ADDR_PORT_DIR: begin
                  dir_r <= 8'(merge_bytes({24'h0, dir_r}, wdata_r, wstrb_r));
               end
               ADDR_PIN_STATE, ADDR_STATUS: begin
                  bresp_r <= RESP_OKAY; // read-only, write ignored
               end
               default: begin
                  bresp_r <= RESP_SLVERR;
               end
            endcase
         end else if (bvalid_r && S_AXI_BREADY) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   assign S_AXI_BVALID = bvalid_r;
   assign S_AXI_BRESP = bresp_r;

   // read decode
   always_comb begin
      read_mux = 32'h0000_0000;
      read_hit = 1'b1;
      unique case ({S_AXI_ARADDR[7:2], 2'b00})
         ADDR_FUNC_SEL: read_mux = {22'h0, func_r};
         ADDR_PORT_DATA: read_mux = {24'h0, data_r};
         ADDR_PORT_DIR: read_mux = {24'h0, dir_r};
         ADDR_PIN_STATE: read_mux = {24'h0, pin_sync_r};
         ADDR_STATUS: begin
            read_mux[STAT_SYS_RUN] = func_r.sys_clk_en && !sys_halt;
            read_mux[STAT_MEM_RUN] = func_r.mclk_en && !mem_halt;
            read_mux[STAT_STANDBY] = stby_sync_r;
            read_mux[STAT_SLEEP] = SLEEP_I;
            read_mux[STAT_STOP] = STOP_I;
         end
         default: read_hit = 1'b0;
      endcase
   end

   // read channel: one read under way, answered the cycle after the address
   assign S_AXI_ARREADY = !rvalid_r;

   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         rvalid_r <= 1'b0;
         rresp_r <= RESP_OKAY;
         rdata_r <= 32'h0000_0000;
      end else begin
         if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            rvalid_r <= 1'b1;
            rdata_r <= read_mux;
            rresp_r <= read_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (rvalid_r && S_AXI_RREADY) begin
            rvalid_r <= 1'b0;
         end
      end
   end

   assign S_AXI_RVALID = rvalid_r;
   assign S_AXI_RDATA = rdata_r;
   assign S_AXI_RRESP = rresp_r;

   // bus clock divider; both clock outputs follow it
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         div_cnt_r <= 8'h00;
         bus_ck_r <= 1'b0;
      end else if (div_cnt_r == 8'(BUS_HALF - 1)) begin
         div_cnt_r <= 8'h00;
         bus_ck_r <= !bus_ck_r;
      end else begin
         div_cnt_r <= div_cnt_r + 8'h01;
      end
   end

   // clock gating by power mode; halts hold the clock low
   assign sys_halt = STOP_I || stby_sync_r;
   assign mem_halt = SLEEP_I || STOP_I || stby_sync_r;

   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         sys_ck_r <= 1'b0;
         mem_ck_r <= 1'b0;
      end else begin
         sys_ck_r <= sys_halt ? 1'b0 : bus_ck_r;
         mem_ck_r <= mem_halt ? 1'b0 : bus_ck_r;
      end
   end

   // pin function select; port mode is the fallback of every pin
   always_comb begin
      port_mode = 8'h00;
      port_mode[0] = !func_r.sys_clk_en;
      port_mode[1] = !func_r.cke_en;
      port_mode[2] = !func_r.mclk_en;
      port_mode[3] = !func_r.reinput_en;
      port_mode[4] = !func_r.load_en && !func_r.addr_strobe_en;
      port_mode[5] = !func_r.adv_en && !func_r.cas_en;
      port_mode[6] = !func_r.cas_en;
      port_mode[7] = !func_r.we_en;
      pin_out_nxt[0] = sys_ck_r;
      pin_out_nxt[1] = STROBE_I.cke;
      pin_out_nxt[2] = mem_ck_r;
      pin_out_nxt[3] = 1'b0;
      // load wins over address strobe when both are set
      pin_out_nxt[4] = func_r.load_en ? STROBE_I.burst_address_load_out
                                     : STROBE_I.address_strobe_out;
      // column strobe lives on pin 6; pin 5 idles high when only it is set
      pin_out_nxt[5] = func_r.adv_en ? STROBE_I.burst_address_advance_out : 1'b1;
      pin_out_nxt[6] = STROBE_I.cas;
      pin_out_nxt[7] = STROBE_I.we;
      pin_oe_nxt = 8'hf7;
      for (int i = 0; i < 8; i++) begin
         if (port_mode[i]) begin
            pin_out_nxt[i] = data_r[i];
            pin_oe_nxt[i] = dir_r[i];
         end
      end
   end

   // registered pin drivers and write strobe outputs
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         pin_out_r <= 8'h00;
         pin_oe_r <= 8'h00;
         wr0_r <= 1'b1;
         wr1_r <= 1'b1;
      end else begin
         pin_out_r <= pin_out_nxt;
         pin_oe_r <= pin_oe_nxt;
         wr0_r <= func_r.sram_mode ? STROBE_I.upper_byte_mask : STROBE_I.wr0;
         wr1_r <= func_r.sram_mode ? STROBE_I.lower_byte_mask : STROBE_I.wr1;
      end
   end

   assign PIN_O = pin_out_r;
   assign PIN_OE_O = pin_oe_r;
   assign WR0_O = wr0_r;
   assign WR1_O = wr1_r;
   // re-input is only meaningful while that pin is released to input
   assign CLK_REIN_O = func_r.reinput_en && pin_sync_r[3];

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!ARST_N_I);

   localparam int TOG_MAX = 8;

   sequence s_sys_halted;
      (func_r.sys_clk_en && sys_halt) [*3];
   endsequence

   sequence s_sys_running;
      (func_r.sys_clk_en && !sys_halt) [*3];
   endsequence

   sequence s_mem_halted;
      (func_r.mclk_en && mem_halt) [*3];
   endsequence

   a_sys_toggles: assert property (s_sys_running |-> ##[0:TOG_MAX] $changed(PIN_O[0]))
      else $error("system clock pin not toggling");
   a_sys_halt: assert property (s_sys_halted |-> !PIN_O[0])
      else $error("system clock runs while halted");
   a_memclk_halt: assert property (s_mem_halted |-> !PIN_O[2])
      else $error("memory clock runs while halted");
   a_port_bits_follow: assert property (1'b1 |=>
         (((PIN_O ^ $past(data_r)) | (PIN_OE_O ^ $past(dir_r))) & $past(port_mode)) == 8'h00)
      else $error("port mode pin not driven from port registers");
   a_bit0_port: assert property (!func_r.sys_clk_en |=> PIN_O[0] == $past(data_r[0]))
      else $error("pin 0 not port bit");
   a_bit1_cke: assert property (func_r.cke_en |=> PIN_O[1] == $past(STROBE_I.cke))
      else $error("pin 1 not clock enable");
   a_reinput_dir: assert property (func_r.reinput_en |=> !PIN_OE_O[3])
      else $error("re-input pin driven");
   a_load_drive: assert property (func_r.load_en |=>
         PIN_O[4] == $past(STROBE_I.burst_address_load_out) && PIN_OE_O[4])
      else $error("pin 4 not address load");
   a_bit4_port: assert property (!func_r.load_en && !func_r.addr_strobe_en |=>
         PIN_O[4] == $past(data_r[4]))
      else $error("pin 4 not port bit");
   a_adv_drive: assert property (func_r.adv_en |=>
         PIN_O[5] == $past(STROBE_I.burst_address_advance_out))
      else $error("pin 5 not address advance");
   a_we_drive: assert property (func_r.we_en |=> PIN_O[7] == $past(STROBE_I.we))
      else $error("pin 7 not write strobe");
   a_sram_masks: assert property (func_r.sram_mode |=>
         WR0_O == $past(STROBE_I.upper_byte_mask) &&
         WR1_O == $past(STROBE_I.lower_byte_mask))
      else $error("byte masks not on write strobe pins");

endmodule : bus_control_pin_mux

`default_nettype wire

// >>> testbench/pin_partner.sv
// far-side model: devices on the external bus and pin pull-ups
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
   input wire logic [7:0] pin_o_i,
   input wire logic [7:0] pin_oe_i,
   input wire logic [7:0] ext_val_i,
   input wire logic [7:0] ext_en_i,
   output logic [7:0] pin_i_o
);
   // device drive wins; otherwise far side, else the pull-up
   assign pin_i_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ext_en_i & ext_val_i)
                    | (~pin_oe_i & ~ext_en_i);
endmodule : pin_partner
`default_nettype wire

// >>> testbench/bus_control_pin_mux_tb.sv
// register-level tests of the bus control pin multiplexer
`timescale 1ns/1ps
`default_nettype none
module bus_control_pin_mux_tb;
   import bus_pin_mux_pkg::*;
   logic clk, arst_n, awv, wv, bready, arv, rready, awr, wr, bv, arr, rv;
   logic sleep, stop, hsb, rein, wr0, wr1;
   logic [7:0] awaddr, araddr, pin_o, pin_oe, pin_i, ext_val, ext_en;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   bus_strobe_type strobe;
   int err_total, compares, tog;
   int fb[6] = '{1, 4, 5, 6, 7, 8};
   int pn[6] = '{1, 4, 4, 5, 6, 7};
   bus_control_pin_mux #(.BUS_HALF(2)) u_bus_control_pin_mux (.CLK_I(clk), .ARST_N_I(arst_n),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bv), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
      .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
      .S_AXI_RREADY(rready), .SLEEP_I(sleep), .STOP_I(stop), .HARDWARE_STANDBY_IN_I(hsb),
      .STROBE_I(strobe), .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE_O(pin_oe), .CLK_REIN_O(rein),
      .WR0_O(wr0), .WR1_O(wr1));
   pin_partner u_pin_partner (.pin_o_i(pin_o), .pin_oe_i(pin_oe), .ext_val_i(ext_val),
      .ext_en_i(ext_en), .pin_i_o(pin_i));
   // free-running 100 MHz core clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : complete_run
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic hang;
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
      complete_run();
   endtask : hang
   // write: both halves offered together, each dropped when taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      bit ta, tw, ad, wd;
      int n;
      ad = 0;
      wd = 0;
      n = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      while (!(ad && wd)) begin
         @(negedge clk);
         ta = !ad && awr;
         tw = !wd && wr;
         @(posedge clk);
         if (ta) begin
            ad = 1;
            awv <= 1'b0;
         end
         if (tw) begin
            wd = 1;
            wv <= 1'b0;
         end
         if (++n > 50) hang();
      end
      n = 0;
      do begin
         @(negedge clk);
         if (++n > 50) hang();
      end while (!bv);
      chk(bresp, er);
      @(posedge clk);
      bready <= 1'b0;
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      bit t;
      int n;
      n = 0;
      t = 0;
      @(posedge clk);
      araddr <= a;
      arv <= 1'b1;
      rready <= 1'b1;
      while (!t) begin
         @(negedge clk);
         t = arr;
         @(posedge clk);
         if (t) arv <= 1'b0;
         if (++n > 50) hang();
      end
      n = 0;
      while (!rv) begin
         @(negedge clk);
         if (++n > 50) hang();
      end
      chk(rdata, ed);
      chk(rresp, er);
      @(posedge clk);
      rready <= 1'b0;
   endtask : axi_rd
   // transitions of one pin over 40 core cycles
   task automatic count_tog(input int b);
      logic p;
      tog = 0;
      @(negedge clk);
      p = pin_o[b];
      repeat (40) begin
         @(negedge clk);
         if (pin_o[b] !== p) tog++;
         p = pin_o[b];
      end
   endtask : count_tog
   task automatic settle;
      repeat (5) @(posedge clk);
      @(negedge clk);
   endtask : settle
   // main sequence
   initial begin
      {awv, wv, bready, arv, rready, sleep, stop, hsb} = '0;
      {awaddr, araddr, ext_val, ext_en} = '0;
      wdata = '0;
      strobe = '0;
      err_total = 0;
      compares = 0;
      arst_n = 1'b0;
      repeat (12) @(posedge clk);
      // pin reset state, looked at while reset still holds it
      chk({wr1, wr0, pin_oe, pin_o}, 18'h30000);
      arst_n <= 1'b1;
      // reset state and unmapped places
      axi_rd(ADDR_FUNC_SEL, 32'h0, RESP_OKAY);
      axi_rd(ADDR_PORT_DIR, 32'h0, RESP_OKAY);
      axi_rd(8'h20, 32'h0, RESP_SLVERR);
      axi_wr(8'h20, 32'h1, RESP_SLVERR);
      $display("reset and map test done");
      // port mode ignores the dedicated strobes
      strobe <= bus_strobe_type'(10'h3ff);
      axi_wr(ADDR_PORT_DATA, 32'ha5, RESP_OKAY);
      axi_wr(ADDR_PORT_DIR, 32'hff, RESP_OKAY);
      settle();
      chk({pin_oe, pin_o}, 16'hffa5);
      @(posedge clk);
      ext_val <= 8'h3c;
      ext_en <= 8'hf0;
      axi_wr(ADDR_PORT_DIR, 32'h0f, RESP_OKAY);
      settle();
      axi_rd(ADDR_PIN_STATE, 32'h35, RESP_OKAY);
      $display("port mode test done");
      // each strobe function on its pin, port data set opposite
      for (int i = 0; i < 6; i++) begin
         for (int v = 0; v < 2; v++) begin
            axi_wr(ADDR_PORT_DATA, v ? 32'h0 : 32'hff, RESP_OKAY);
            axi_wr(ADDR_FUNC_SEL, 32'h1 << fb[i], RESP_OKAY);
            strobe <= bus_strobe_type'(v ? 10'h001 << i : 10'h000);
            settle();
            chk({pin_oe[pn[i]], pin_o[pn[i]]}, {1'b1, v[0]});
            if (i == 4 && v == 1) chk({pin_oe[5], pin_o[5]}, 2'b11);
         end
      end
      $display("strobe function test done");
      // system clock runs at the bus rate, halts in stop and standby
      axi_wr(ADDR_FUNC_SEL, 32'h005, RESP_OKAY);
      count_tog(0);
      chk(tog >= 19 && tog <= 21, 1);
      count_tog(2);
      chk(tog >= 19 && tog <= 21, 1);
      @(posedge clk);
      sleep <= 1'b1;
      settle();
      count_tog(2);
      chk({tog[30:0], pin_o[2]}, 0);
      count_tog(0);
      chk(tog >= 19 && tog <= 21, 1);
      axi_rd(ADDR_STATUS, 32'h09, RESP_OKAY);
      sleep <= 1'b0;
      stop <= 1'b1;
      settle();
      count_tog(0);
      chk({tog[30:0], pin_o[0]}, 0);
      axi_rd(ADDR_STATUS, 32'h10, RESP_OKAY);
      stop <= 1'b0;
      hsb <= 1'b1;
      settle();
      count_tog(2);
      chk({tog[30:0], pin_o[2]}, 0);
      count_tog(0);
      chk(tog, 0);
      axi_rd(ADDR_STATUS, 32'h04, RESP_OKAY);
      hsb <= 1'b0;
      // port bit 0 set high so a stuck clock or halt level cannot pass
      axi_wr(ADDR_PORT_DATA, 32'h01, RESP_OKAY);
      axi_wr(ADDR_FUNC_SEL, 32'h0, RESP_OKAY);
      settle();
      chk(pin_o[0], 1'b1);
      $display("clock gating test done");
      // clock re-input follows pin 3 with the pin not driven
      @(posedge clk);
      ext_en <= 8'h08;
      ext_val <= 8'h08;
      axi_wr(ADDR_FUNC_SEL, 32'h008, RESP_OKAY);
      settle();
      chk({pin_oe[3], rein}, 2'b01);
      @(posedge clk);
      ext_val <= 8'h00;
      settle();
      chk(rein, 1'b0);
      $display("clock reinput test done");
      // write strobe pins swap to byte masks in sram mode
      @(posedge clk);
      strobe <= bus_strobe_type'(10'h140);
      axi_wr(ADDR_FUNC_SEL, 32'h200, RESP_OKAY);
      settle();
      chk({wr1, wr0}, 2'b10);
      axi_wr(ADDR_FUNC_SEL, 32'h0, RESP_OKAY);
      settle();
      chk({wr1, wr0}, 2'b01);
      $display("sram mask test done");
      complete_run();
   end
endmodule : bus_control_pin_mux_tb
`default_nettype wire
